// ==== remote_select_map.svh ====
// Constants for the remote source select and multi-unit link block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef REMOTE_SELECT_MAP_SVH
`define REMOTE_SELECT_MAP_SVH

// ****************************************************************
// Sizes and timing
// ****************************************************************
`define ALARM_INPUTS 8
`define DEBOUNCE_US 1000
`define CLOCK_MHZ 100
`define DEBOUNCE_CYCLES (`DEBOUNCE_US * `CLOCK_MHZ)

// ****************************************************************
// Source codes
// ****************************************************************
`define SOURCE_FIRST 1'b0
`define SOURCE_SECOND 1'b1

`endif

// ==== remote_select_pkg.sv ====
// Types shared by the remote source select design.
// Assumes the constant header is on the include path.
`include "remote_select_map.svh"

package remote_select_pkg;

  // ****************************************************************
  // Arbitration record
  // ****************************************************************
  typedef enum logic [1:0] {
    HONOUR_NONE = 2'b00,
    HONOUR_FIRST = 2'b01,
    HONOUR_SECOND = 2'b10
  } honour_type;

  // ****************************************************************
  // Backup source claim
  // ****************************************************************
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_CLAIMED = 2'b01,
    LINK_RETURNING = 2'b10
  } link_type;

endpackage : remote_select_pkg

// ==== contact_debounce.sv ====
// Synchroniser and debouncer for one dry-contact input.
// Assumes the contact level is asynchronous to SYS_CLK.
`timescale 1ns/10ps
`default_nettype none

module contact_debounce #(
  parameter int STABLE_CYCLES = 100000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw,
  output logic clean
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);

  logic meta_r;
  logic sync_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  wire differs = (sync_r != clean);
  wire settled = (count_r == CW'(STABLE_CYCLES - 1));

  // A change is taken only after the synchronised level held steady.
  assign count_nxt = (!differs || settled) ? '0 : count_r + CW'(1);

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      count_r <= '0;
      clean <= 1'b0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
      count_r <= count_nxt;
      if (differs && settled) begin
        clean <= sync_r;
      end
    end
  end

endmodule : contact_debounce

`default_nettype wire

// ==== remote_source_select_link.sv ====
// Remote preferred-source selection, building alarm points and the
// multi-unit backup-source lockout of a transfer switch unit.
// Assumes open contacts read 0, closed read 1, on raw asynchronous pins;
// peer link and local panel levels come from pins too and are synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "remote_select_map.svh"

module remote_source_select_link
  import remote_select_pkg::*;
#(
  parameter int STABLE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int ALARMS = `ALARM_INPUTS
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [ALARMS-1:0] BUILDING_ALARM_CONTACT,
  input wire logic REMOTE_PICK_FIRST_SOURCE,
  input wire logic REMOTE_PICK_SECOND_SOURCE,
  input wire logic PANEL_PREFERRED_SOURCE,
  input wire logic PANEL_RETRANSFER_ENABLE,
  input wire logic PEER_BACKUP_IN_USE,
  input wire logic LINK_ENABLE,
  input wire logic BACKUP_TRANSFER_REQUEST,
  input wire logic LOAD_ON_BACKUP,
  input wire logic PREFERRED_SOURCE_NORMAL,
  input wire logic WEB_WRITE_REQUEST,
  output logic [ALARMS-1:0] ALARM_POINT,
  output logic PREFERRED_SOURCE,
  output logic REMOTE_CONTROL_ACTIVE,
  output logic RETRANSFER_ENABLE,
  output logic BACKUP_IN_USE,
  output logic BACKUP_TRANSFER_PERMIT,
  output logic TRANSFER_INHIBIT_ALARM,
  output logic WEB_WRITE_REJECTED
);

  // ****************************************************************
  // Contact conditioning
  // ****************************************************************
  logic [ALARMS-1:0] alarm_clean;
  logic pick_first;
  logic pick_second;

  genvar g;
  generate
    for (g = 0; g < ALARMS; g++) begin : g_alarm
      contact_debounce #(.STABLE_CYCLES(STABLE_CYCLES)) u_alarm (
        .clk(SYS_CLK),
        .rst(RESET),
        .raw(BUILDING_ALARM_CONTACT[g]),
        .clean(alarm_clean[g])
      );
    end
  endgenerate

  contact_debounce #(.STABLE_CYCLES(STABLE_CYCLES)) u_pick_first (
    .clk(SYS_CLK),
    .rst(RESET),
    .raw(REMOTE_PICK_FIRST_SOURCE),
    .clean(pick_first)
  );

  contact_debounce #(.STABLE_CYCLES(STABLE_CYCLES)) u_pick_second (
    .clk(SYS_CLK),
    .rst(RESET),
    .raw(REMOTE_PICK_SECOND_SOURCE),
    .clean(pick_second)
  );

  // Panel and peer levels are pins but not contacts: two flops, no filter.
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  wire panel_source = pin_sync_r[0];
  wire panel_retransfer = pin_sync_r[1];
  wire peer_in_use = pin_sync_r[2];

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {PEER_BACKUP_IN_USE, PANEL_RETRANSFER_ENABLE, PANEL_PREFERRED_SOURCE};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************************************
  // Building alarm points
  // ****************************************************************
  // The points feed nothing else here, so an alarm can never steer a transfer.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ALARM_POINT <= '0;
    end else begin
      ALARM_POINT <= alarm_clean;
    end
  end

  // ****************************************************************
  // Remote select arbitration
  // ****************************************************************
  honour_type honour_r;
  honour_type honour_nxt;

  // Simultaneous first closure of both goes to source one; each debouncer
  // keeps its own count of equal length, so a true tie needs edges within one cycle.
  always_comb begin
    honour_nxt = honour_r;
    unique case (honour_r)
      HONOUR_NONE: begin
        if (pick_first) begin
          honour_nxt = HONOUR_FIRST;
        end else if (pick_second) begin
          honour_nxt = HONOUR_SECOND;
        end
      end
      HONOUR_FIRST: begin
        if (!pick_first) begin
          honour_nxt = pick_second ? HONOUR_SECOND : HONOUR_NONE;
        end
      end
      HONOUR_SECOND: begin
        if (!pick_second) begin
          honour_nxt = pick_first ? HONOUR_FIRST : HONOUR_NONE;
        end
      end
      default: begin
        honour_nxt = HONOUR_NONE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      honour_r <= HONOUR_NONE;
    end else begin
      honour_r <= honour_nxt;
    end
  end

  wire remote_active = (honour_r != HONOUR_NONE);
  wire remote_source = (honour_r == HONOUR_SECOND) ? `SOURCE_SECOND : `SOURCE_FIRST;
  wire source_sel = remote_active ? remote_source : panel_source;
  wire retransfer_sel = remote_active | panel_retransfer;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PREFERRED_SOURCE <= `SOURCE_FIRST;
      REMOTE_CONTROL_ACTIVE <= 1'b0;
      RETRANSFER_ENABLE <= 1'b0;
    end else begin
      PREFERRED_SOURCE <= source_sel;
      REMOTE_CONTROL_ACTIVE <= remote_active;
      RETRANSFER_ENABLE <= retransfer_sel;
    end
  end

  // ****************************************************************
  // Multi-unit backup source link
  // ****************************************************************
  link_type link_r;
  link_type link_nxt;

  always_comb begin
    link_nxt = link_r;
    unique case (link_r)
      LINK_IDLE: begin
        if (LINK_ENABLE && LOAD_ON_BACKUP && !peer_in_use) begin
          link_nxt = LINK_CLAIMED;
        end
      end
      LINK_CLAIMED: begin
        if (PREFERRED_SOURCE_NORMAL) begin
          link_nxt = LINK_RETURNING;
        end
      end
      LINK_RETURNING: begin
        if (!PREFERRED_SOURCE_NORMAL) begin
          link_nxt = LINK_CLAIMED;
        end else if (!LOAD_ON_BACKUP) begin
          link_nxt = LINK_IDLE;
        end
      end
      default: begin
        link_nxt = LINK_IDLE;
      end
    endcase
    if (!LINK_ENABLE) begin
      link_nxt = LINK_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      link_r <= LINK_IDLE;
    end else begin
      link_r <= link_nxt;
    end
  end

  wire own_claim = (link_r != LINK_IDLE);
  wire peer_block = LINK_ENABLE & peer_in_use & !own_claim;

  assign BACKUP_IN_USE = own_claim;
  assign BACKUP_TRANSFER_PERMIT = BACKUP_TRANSFER_REQUEST & !peer_block;
  assign TRANSFER_INHIBIT_ALARM = LINK_ENABLE & (own_claim | peer_in_use);

  // ****************************************************************
  // Status web path
  // ****************************************************************
  // Nothing on this path reaches any register above; writes are only flagged.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      WEB_WRITE_REJECTED <= 1'b0;
    end else begin
      WEB_WRITE_REJECTED <= WEB_WRITE_REQUEST;
    end
  end

endmodule : remote_source_select_link

`default_nettype wire

// ==== remote_source_select_link_checker.sv ====
// Port assertions for the remote select and multi-unit link block.
// Assumes it is bound onto remote_source_select_link with matching parameters.
`timescale 1ns/10ps
`default_nettype none
module remote_source_select_link_checker #(
  parameter int STABLE_CYCLES = 4,
  parameter int ALARMS = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [ALARMS-1:0] BUILDING_ALARM_CONTACT,
  input wire logic REMOTE_PICK_FIRST_SOURCE,
  input wire logic PEER_BACKUP_IN_USE,
  input wire logic LINK_ENABLE,
  input wire logic LOAD_ON_BACKUP,
  input wire logic PREFERRED_SOURCE_NORMAL,
  input wire logic WEB_WRITE_REQUEST,
  input wire logic [ALARMS-1:0] ALARM_POINT,
  input wire logic PREFERRED_SOURCE,
  input wire logic REMOTE_CONTROL_ACTIVE,
  input wire logic RETRANSFER_ENABLE,
  input wire logic BACKUP_IN_USE,
  input wire logic BACKUP_TRANSFER_PERMIT,
  input wire logic TRANSFER_INHIBIT_ALARM,
  input wire logic WEB_WRITE_REJECTED
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Counts how long alarm contact 0 has stayed closed; saturates to stay small.
  int high_cnt;
  always_ff @(posedge SYS_CLK) begin
    if (!BUILDING_ALARM_CONTACT[0]) begin
      high_cnt <= 0;
    end else if (high_cnt < STABLE_CYCLES + 8) begin
      high_cnt <= high_cnt + 1;
    end
  end
  property p_web; WEB_WRITE_REQUEST |=> WEB_WRITE_REJECTED; endproperty
  a_web: assert property (p_web) else $error("web write not refused");
  property p_retx; $rose(REMOTE_CONTROL_ACTIVE) |-> ##[0:1] RETRANSFER_ENABLE; endproperty
  a_retx: assert property (p_retx) else $error("retransfer not forced");
  // The peer level reaches the claim logic two flops late, hence the depth of two.
  property p_claim;
    LINK_ENABLE && LOAD_ON_BACKUP && (BACKUP_IN_USE || !$past(PEER_BACKUP_IN_USE, 2))
      |=> BACKUP_IN_USE;
  endproperty
  a_claim: assert property (p_claim) else $error("backup claim missing");
  property p_inhibit; BACKUP_IN_USE && LINK_ENABLE |-> TRANSFER_INHIBIT_ALARM; endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit alarm missing");
  property p_block;
    PEER_BACKUP_IN_USE [*3] ##0 (LINK_ENABLE && !BACKUP_IN_USE) |-> !BACKUP_TRANSFER_PERMIT;
  endproperty
  a_block: assert property (p_block) else $error("transfer not blocked by peer");
  property p_hold;
    BACKUP_IN_USE && LINK_ENABLE && LOAD_ON_BACKUP && !PREFERRED_SOURCE_NORMAL
      |=> BACKUP_IN_USE;
  endproperty
  a_hold: assert property (p_hold) else $error("claim released early");
  property p_debounce; $rose(ALARM_POINT[0]) |-> high_cnt >= STABLE_CYCLES; endproperty
  a_debounce: assert property (p_debounce) else $error("alarm taken too soon");
  property p_first;
    REMOTE_PICK_FIRST_SOURCE [*8] ##0 (REMOTE_CONTROL_ACTIVE && !PREFERRED_SOURCE)
      |=> !PREFERRED_SOURCE;
  endproperty
  a_first: assert property (p_first) else $error("first closure not kept");
  c_remote: cover property ($rose(REMOTE_CONTROL_ACTIVE));
  c_claim: cover property ($rose(BACKUP_IN_USE));
  c_block: cover property ($fell(BACKUP_TRANSFER_PERMIT));
endmodule : remote_source_select_link_checker
`default_nettype wire

// ==== far_side_model.sv ====
// Far side: building and remote select contacts plus one peer unit.
// Assumes the bench asks for levels; pins move on the clock edge.
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
  input wire logic clk,
  input wire logic [9:0] want,
  input wire logic peer_claim,
  output logic [7:0] alarm_pin,
  output logic first_pin,
  output logic second_pin,
  output logic peer_pin
);
  // The peer keeps its claim until it has retransferred, as the bench orders.
  always_ff @(posedge clk) begin
    {alarm_pin, first_pin, second_pin} <= want;
    peer_pin <= peer_claim;
  end
endmodule : far_side_model
`default_nettype wire

// ==== remote_source_select_link_tb_top.sv ====
// Self-checking bench for the remote select and multi-unit link block.
// Assumes a short debounce so each contact settles within 16 cycles.
`timescale 1ns/10ps
`default_nettype none
module remote_source_select_link_tb_top;
  localparam int STABLE = 4;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [9:0] want = 10'h000;
  logic peer_claim = 1'h0;
  logic panel_pref = 1'h0;
  logic panel_retx = 1'h0;
  logic link_en = 1'h0;
  logic req = 1'h0;
  logic on_backup = 1'h0;
  logic normal = 1'h0;
  logic web = 1'h0;
  wire logic [7:0] alarm_pin, alarm_point;
  wire logic first_pin, second_pin, peer_pin, pref, act, retx, in_use, permit, inhibit, rej;
  wire logic [7:0] flags = {1'h0, pref, act, retx, in_use, permit, inhibit, rej};
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  far_side_model u_far_side_model (.clk(clk), .want(want), .peer_claim(peer_claim),
    .alarm_pin(alarm_pin), .first_pin(first_pin), .second_pin(second_pin),
    .peer_pin(peer_pin));
  remote_source_select_link #(.STABLE_CYCLES(STABLE)) u_remote_source_select_link (
    .SYS_CLK(clk), .RESET(rst), .BUILDING_ALARM_CONTACT(alarm_pin),
    .REMOTE_PICK_FIRST_SOURCE(first_pin), .REMOTE_PICK_SECOND_SOURCE(second_pin),
    .PANEL_PREFERRED_SOURCE(panel_pref), .PANEL_RETRANSFER_ENABLE(panel_retx),
    .PEER_BACKUP_IN_USE(peer_pin), .LINK_ENABLE(link_en), .BACKUP_TRANSFER_REQUEST(req),
    .LOAD_ON_BACKUP(on_backup), .PREFERRED_SOURCE_NORMAL(normal), .WEB_WRITE_REQUEST(web),
    .ALARM_POINT(alarm_point), .PREFERRED_SOURCE(pref), .REMOTE_CONTROL_ACTIVE(act),
    .RETRANSFER_ENABLE(retx), .BACKUP_IN_USE(in_use), .BACKUP_TRANSFER_PERMIT(permit),
    .TRANSFER_INHIBIT_ALARM(inhibit), .WEB_WRITE_REJECTED(rej));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Sampling 1 ns after the edge keeps clear of that edge's own updates.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic contacts(input logic [9:0] v);
    @(posedge clk);
    want <= v;
    settle(16);
  endtask : contacts
  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Every stimulus change is made on a rising edge, so each one first
  // waits for that edge after the previous check.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    settle(0);
    chk("flags", 8'h00, flags);
    contacts(10'h294);
    chk("alarm_point", 8'hA5, alarm_point);
    chk("flags", 8'h00, flags);
    @(posedge clk);
    want <= 10'h29C;
    repeat (2) @(posedge clk);
    want <= 10'h294;
    panel_pref <= 1'h1;
    settle(16);
    chk("alarm_point", 8'hA5, alarm_point);
    chk("flags", 8'h40, flags);
    contacts(10'h296);
    chk("flags", 8'h30, flags);
    contacts(10'h297);
    chk("flags", 8'h30, flags);
    contacts(10'h295);
    chk("flags", 8'h70, flags);
    @(posedge clk);
    panel_pref <= 1'h0;
    contacts(10'h294);
    chk("flags", 8'h00, flags);
    @(posedge clk);
    panel_retx <= 1'h1;
    settle(4);
    chk("flags", 8'h10, flags);
    @(posedge clk);
    panel_retx <= 1'h0;
    contacts(10'h295);
    chk("flags", 8'h70, flags);
    contacts(10'h297);
    chk("flags", 8'h70, flags);
    contacts(10'h294);
    @(posedge clk);
    web <= 1'h1;
    settle(2);
    chk("flags", 8'h01, flags);
    @(posedge clk);
    web <= 1'h0;
    link_en <= 1'h1;
    on_backup <= 1'h1;
    settle(2);
    chk("flags", 8'h0A, flags);
    @(posedge clk);
    normal <= 1'h1;
    settle(2);
    chk("flags", 8'h0A, flags);
    // Preferred source fails again in the same cycle the load comes off backup: the claim must stay.
    @(posedge clk);
    normal <= 1'h0;
    on_backup <= 1'h0;
    settle(2);
    chk("flags", 8'h0A, flags);
    @(posedge clk);
    normal <= 1'h1;
    settle(3);
    chk("flags", 8'h00, flags);
    @(posedge clk);
    normal <= 1'h0;
    req <= 1'h1;
    peer_claim <= 1'h1;
    settle(6);
    chk("flags", 8'h02, flags);
    @(posedge clk);
    on_backup <= 1'h1;
    settle(2);
    chk("flags", 8'h02, flags);
    @(posedge clk);
    on_backup <= 1'h0;
    peer_claim <= 1'h0;
    settle(6);
    chk("flags", 8'h04, flags);
    @(posedge clk);
    link_en <= 1'h0;
    peer_claim <= 1'h1;
    settle(6);
    chk("flags", 8'h04, flags);
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule : remote_source_select_link_tb_top
bind remote_source_select_link remote_source_select_link_checker #(
  .STABLE_CYCLES(STABLE_CYCLES), .ALARMS(ALARMS)) u_chk (.SYS_CLK, .RESET,
  .BUILDING_ALARM_CONTACT, .REMOTE_PICK_FIRST_SOURCE, .PEER_BACKUP_IN_USE, .LINK_ENABLE,
  .LOAD_ON_BACKUP, .PREFERRED_SOURCE_NORMAL, .WEB_WRITE_REQUEST, .ALARM_POINT,
  .PREFERRED_SOURCE, .REMOTE_CONTROL_ACTIVE, .RETRANSFER_ENABLE, .BACKUP_IN_USE,
  .BACKUP_TRANSFER_PERMIT, .TRANSFER_INHIBIT_ALARM, .WEB_WRITE_REJECTED);
`default_nettype wire
